// ===== logic/core_clock_map.svh
`ifndef CORE_CLOCK_MAP_SVH
`define CORE_CLOCK_MAP_SVH

// Reset divider fields and the fixed core divide-by-three field, stored as divide value minus one
`define RATIO_THIRD_RST   3'h2
`define RATIO_TRACE_RST   3'h3
`define RATIO_SIXTH_RST   3'h5
`define RATIO_MEMIF_RST   3'h3
`define RATIO_COPROCQ_RST 3'h3
`define RATIO_COPROCH_RST 3'h1
`define RATIO_CORE3_FIX   3'h2

// Domain positions inside the packed divider vectors
`define IDX_THIRD   0
`define IDX_TRACE   1
`define IDX_SIXTH   2
`define IDX_MEMIF   3
`define IDX_COPROCQ 4
`define IDX_COPROCH 5
`define NUM_DOMAINS 6

`endif

// ===== logic/core_clock_pkg.sv
package core_clock_pkg;

  // Clocking mode of the main PLL path
  typedef enum logic {
    MODE_BYPASS,
    MODE_PLL
  } clk_mode_t;

endpackage : core_clock_pkg

// ===== logic/ratio_divider.sv
`timescale 1ns/100ps
module ratio_divider #(
  parameter int RATIO_W = 4
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // Core tick and realign request
  input  wire logic               tick,
  input  wire logic               clear,
  // Divide value minus one
  input  wire logic [RATIO_W-1:0] ratio,
  // Divided enable pulse
  output logic                    pulse
);

  logic [RATIO_W-1:0] cnt_ff;
  logic [RATIO_W-1:0] nxt_cnt;
  logic               pulse_ff;
  logic               nxt_pulse;

  // Count core ticks; pulse on tick number ratio+1
  always_comb begin
    nxt_cnt   = cnt_ff;
    nxt_pulse = 1'b0;
    if (clear) begin
      nxt_cnt = '0;
    end else if (tick) begin
      if (cnt_ff >= ratio) begin
        nxt_cnt   = '0;
        nxt_pulse = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + RATIO_W'(1);
      end
    end
  end

  // Register counter and pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff   <= '0;
      pulse_ff <= 1'b0;
    end else begin
      cnt_ff   <= nxt_cnt;
      pulse_ff <= nxt_pulse;
    end
  end

  assign pulse = pulse_ff;

endmodule : ratio_divider

// ===== logic/core_clock_ratio_divider.sv
// What this block does
// [RULE1] Leave reset in PLL bypass mode and stay there until the PLL mode request is raised.
// [RULE2] In PLL mode the core runs from the multiplied PLL output instead of the reference.
// [RULE3] The core full-rate domain enable follows the selected source with no division.
// [RULE4] The third-rate system enable runs at one third of the core rate.
// [RULE5] The sixth-rate system enable runs at one sixth of the core rate.
// [RULE6] The coprocessor full-rate enable runs at one half of the core rate.
// [RULE7] The memory interface enable runs at one quarter of the core rate.
// [RULE8] The trace enable runs at one quarter of the core rate as its own output.
// [RULE9] The coprocessor half-rate enable runs at one quarter of the core rate as its own output.
// [RULE10] All derived enables come from one source, stay synchronous and share aligned edges.
// [RULE11] The core makes its own fixed divide-by-three enable for on-chip communication.
// [RULE12] The configuring party must set each divider field to its required fixed ratio.
// [RULE13] Each divider field holds the divide value minus one.
// [RULE14] A divider or mode change realigns all dividers cleanly to one common core edge.
`timescale 1ns/100ps
`include "core_clock_map.svh"
module core_clock_ratio_divider
  import core_clock_pkg::*;
#(
  parameter int RATIO_W = 4
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // Source selection
  input  wire logic               pll_mode_req,
  input  wire logic               ref_tick,
  // Divider fields, divide value minus one
  input  wire logic [RATIO_W-1:0] ratio_third,
  input  wire logic [RATIO_W-1:0] ratio_trace,
  input  wire logic [RATIO_W-1:0] ratio_sixth,
  input  wire logic [RATIO_W-1:0] ratio_memif,
  input  wire logic [RATIO_W-1:0] ratio_coproc_q,
  input  wire logic [RATIO_W-1:0] ratio_coproc_h,
  // Domain enables
  output logic                    core_full_rate_en,
  output logic                    core_div3_en,
  output logic                    sys_clock_third,
  output logic                    sys_clock_trace_quarter,
  output logic                    sys_clock_sixth,
  output logic                    sys_clock_memif_quarter,
  output logic                    sys_clock_coproc_quarter,
  output logic                    sys_clock_coproc_half,
  // Status
  output logic                    pll_active,
  output logic                    ratio_ok
);

  // Refuse field widths that cannot hold the fixed reset fields
  if (RATIO_W < 3 || RATIO_W > 16) begin : g_bad_ratio_w
    $error("RATIO_W must lie between 3 and 16");
  end

  localparam int N = `NUM_DOMAINS;

  clk_mode_t                      mode_ff;
  clk_mode_t                      nxt_mode;
  logic      [N-1:0][RATIO_W-1:0] ratio_in;
  logic      [N-1:0][RATIO_W-1:0] ratio_ff;
  logic      [N-1:0][RATIO_W-1:0] nxt_ratio;
  logic      [N-1:0]              dom_pulse;
  logic                           realign;
  logic                           core_tick;
  logic                           core_en_ff;
  logic                           nxt_core_en;
  logic                           ratio_ok_ff;
  logic                           nxt_ratio_ok;

  assign ratio_in[`IDX_THIRD]   = ratio_third;
  assign ratio_in[`IDX_TRACE]   = ratio_trace;
  assign ratio_in[`IDX_SIXTH]   = ratio_sixth;
  assign ratio_in[`IDX_MEMIF]   = ratio_memif;
  assign ratio_in[`IDX_COPROCQ] = ratio_coproc_q;
  assign ratio_in[`IDX_COPROCH] = ratio_coproc_h;

  // Mode machine: bypass after reset, PLL only on request
  always_comb begin
    nxt_mode = mode_ff;
    unique case (mode_ff)
      MODE_BYPASS: if (pll_mode_req) nxt_mode = MODE_PLL;  // RULE1
      MODE_PLL:    if (!pll_mode_req) nxt_mode = MODE_BYPASS;
    endcase
  end

  // Any field or mode change forces a common restart
  always_comb begin
    realign   = (nxt_mode != mode_ff) || (ratio_in != ratio_ff);  // RULE14
    nxt_ratio = ratio_in;  // RULE14
  end

  // Core source: PLL output every cycle, or reference ticks in bypass
  always_comb begin
    core_tick    = (mode_ff == MODE_PLL) ? 1'b1 : ref_tick;  // RULE2
    nxt_core_en  = core_tick && !realign;  // RULE3
    nxt_ratio_ok = (ratio_ff[`IDX_THIRD]   == RATIO_W'(`RATIO_THIRD_RST))
                && (ratio_ff[`IDX_TRACE]   == RATIO_W'(`RATIO_TRACE_RST))
                && (ratio_ff[`IDX_SIXTH]   == RATIO_W'(`RATIO_SIXTH_RST))
                && (ratio_ff[`IDX_MEMIF]   == RATIO_W'(`RATIO_MEMIF_RST))
                && (ratio_ff[`IDX_COPROCQ] == RATIO_W'(`RATIO_COPROCQ_RST))
                && (ratio_ff[`IDX_COPROCH] == RATIO_W'(`RATIO_COPROCH_RST));
  end

  // Register mode, held fields and core enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff     <= MODE_BYPASS;  // RULE1
      ratio_ff[`IDX_THIRD]   <= RATIO_W'(`RATIO_THIRD_RST);
      ratio_ff[`IDX_TRACE]   <= RATIO_W'(`RATIO_TRACE_RST);
      ratio_ff[`IDX_SIXTH]   <= RATIO_W'(`RATIO_SIXTH_RST);
      ratio_ff[`IDX_MEMIF]   <= RATIO_W'(`RATIO_MEMIF_RST);
      ratio_ff[`IDX_COPROCQ] <= RATIO_W'(`RATIO_COPROCQ_RST);
      ratio_ff[`IDX_COPROCH] <= RATIO_W'(`RATIO_COPROCH_RST);
      core_en_ff  <= 1'b0;
      ratio_ok_ff <= 1'b1;
    end else begin
      mode_ff     <= nxt_mode;
      ratio_ff    <= nxt_ratio;
      core_en_ff  <= nxt_core_en;
      ratio_ok_ff <= nxt_ratio_ok;
    end
  end

  // One divider per derived domain, all counting the same core tick
  for (genvar i = 0; i < N; i++) begin : g_dom
    ratio_divider #(
      .RATIO_W (RATIO_W)
    ) u_div (
      .clk   (clk),
      .rst_n (rst_n),
      .tick  (core_tick),  // RULE10
      .clear (realign),  // RULE14
      .ratio (ratio_ff[i]),  // RULE13
      .pulse (dom_pulse[i])
    );
  end

  // Core-internal fixed divide-by-three
  ratio_divider #(
    .RATIO_W (RATIO_W)
  ) u_core_div3 (
    .clk   (clk),
    .rst_n (rst_n),
    .tick  (core_tick),
    .clear (realign),
    .ratio (RATIO_W'(`RATIO_CORE3_FIX)),  // RULE11
    .pulse (core_div3_en)
  );

  // Outputs straight from flip-flops
  assign core_full_rate_en        = core_en_ff;
  assign sys_clock_third          = dom_pulse[`IDX_THIRD];  // RULE4
  assign sys_clock_trace_quarter  = dom_pulse[`IDX_TRACE];  // RULE8
  assign sys_clock_sixth          = dom_pulse[`IDX_SIXTH];  // RULE5
  assign sys_clock_memif_quarter  = dom_pulse[`IDX_MEMIF];  // RULE7
  assign sys_clock_coproc_quarter = dom_pulse[`IDX_COPROCQ];  // RULE9
  assign sys_clock_coproc_half    = dom_pulse[`IDX_COPROCH];  // RULE6
  assign pll_active               = (mode_ff == MODE_PLL);
  assign ratio_ok                 = ratio_ok_ff;

  // Checking helpers: core enables seen since each domain's last pulse
  logic [N-1:0][RATIO_W-1:0] gap_ff;
  logic [N-1:0][RATIO_W-1:0] nxt_gap;

  // Next gaps: restart on realign or on a pulse, count other core enables
  always_comb begin
    for (int k = 0; k < N; k++) begin
      nxt_gap[k] = gap_ff[k];
      if (realign || (core_en_ff && dom_pulse[k])) begin
        nxt_gap[k] = '0;
      end else if (core_en_ff) begin
        nxt_gap[k] = gap_ff[k] + RATIO_W'(1);
      end
    end
  end

  // Register the gaps
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_ff <= '0;
    end else begin
      gap_ff <= nxt_gap;
    end
  end

  // Checking helper: core enables seen since the last fixed divide-by-three pulse
  logic [RATIO_W-1:0] gap3_ff;
  logic [RATIO_W-1:0] nxt_gap3;

  // Next gap: restart on realign or on a pulse, count other core enables
  always_comb begin
    nxt_gap3 = gap3_ff;
    if (realign || (core_en_ff && core_div3_en)) begin
      nxt_gap3 = '0;
    end else if (core_en_ff) begin
      nxt_gap3 = gap3_ff + RATIO_W'(1);
    end
  end

  // Register the gap
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap3_ff <= '0;
    end else begin
      gap3_ff <= nxt_gap3;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Mode entry and core enable source
  a_mode_needs_req: assert property ( // RULE1
    $changed(mode_ff) && (mode_ff == MODE_PLL) |-> $past(pll_mode_req))
    else $error("PLL mode entered without request");
  a_pll_full_rate: assert property ( // RULE2
    (mode_ff == MODE_PLL) && $past(mode_ff == MODE_PLL) && !realign |=> core_full_rate_en)
    else $error("PLL mode core enable missing");
  a_bypass_follows_ref: assert property ( // RULE3
    (mode_ff == MODE_BYPASS) && !realign |=> (core_full_rate_en == $past(ref_tick)))
    else $error("Bypass core enable does not follow reference");

  // Pulse spacing against the fixed fields, while they hold
  a_third_rate_gap: assert property ( // RULE4
    sys_clock_third && ratio_ok_ff |-> gap_ff[`IDX_THIRD] == RATIO_W'(3'h2))
    else $error("Third-rate pulse spacing wrong");
  a_sixth_rate_gap: assert property ( // RULE5
    sys_clock_sixth && ratio_ok_ff |-> gap_ff[`IDX_SIXTH] == RATIO_W'(3'h5))
    else $error("Sixth-rate pulse spacing wrong");
  a_half_rate_gap: assert property ( // RULE6
    sys_clock_coproc_half && ratio_ok_ff |-> gap_ff[`IDX_COPROCH] == RATIO_W'(3'h1))
    else $error("Half-rate pulse spacing wrong");
  a_memif_quarter_gap: assert property ( // RULE7
    sys_clock_memif_quarter && ratio_ok_ff |-> gap_ff[`IDX_MEMIF] == RATIO_W'(3'h3))
    else $error("Memory interface pulse spacing wrong");
  a_trace_quarter_gap: assert property ( // RULE8
    sys_clock_trace_quarter && ratio_ok_ff |-> gap_ff[`IDX_TRACE] == RATIO_W'(3'h3))
    else $error("Trace pulse spacing wrong");
  a_coproc_quarter_gap: assert property ( // RULE9
    sys_clock_coproc_quarter && ratio_ok_ff |-> gap_ff[`IDX_COPROCQ] == RATIO_W'(3'h3))
    else $error("Coprocessor quarter pulse spacing wrong");

  // Common edges across domains, fields and realign
  a_edges_aligned: assert property ( // RULE10
    sys_clock_sixth && ratio_ok_ff |-> sys_clock_third && sys_clock_coproc_half
                                     && core_full_rate_en)
    else $error("Derived enables not aligned");
  a_core_div3_align: assert property ( // RULE11
    core_div3_en && ratio_ok_ff |-> sys_clock_third && core_full_rate_en)
    else $error("Core divide-by-three not aligned");
  a_field_minus_one: assert property ( // RULE13
    sys_clock_third |-> gap_ff[`IDX_THIRD] == ratio_ff[`IDX_THIRD])
    else $error("Divider field not honoured as value minus one");
  a_realign_quiet: assert property ( // RULE14
    realign |=> !(|dom_pulse) && !core_div3_en && !core_full_rate_en)
    else $error("Pulse emitted across realign");

  // Mode holds while the request agrees with it, and PLL mode returns to bypass when the request drops
  a_bypass_holds: assert property ( // RULE1
    (mode_ff == MODE_BYPASS) && !pll_mode_req |=> (mode_ff == MODE_BYPASS))
    else $error("Bypass mode left without request");
  a_pll_holds: assert property ( // RULE2
    (mode_ff == MODE_PLL) && pll_mode_req |=> (mode_ff == MODE_PLL))
    else $error("PLL mode left while still requested");
  a_bypass_on_drop: assert property ( // RULE1
    (mode_ff == MODE_PLL) && !pll_mode_req |=> (mode_ff == MODE_BYPASS))
    else $error("Bypass not restored after request dropped");

  // Every derived pulse rides on a core enable
  a_pulse_on_core: assert property ( // RULE10
    (|dom_pulse) || core_div3_en |-> core_full_rate_en)
    else $error("Derived pulse without core enable");
  a_quarters_together: assert property ( // RULE10
    sys_clock_memif_quarter && ratio_ok_ff |-> sys_clock_trace_quarter
                                            && sys_clock_coproc_quarter
                                            && sys_clock_coproc_half)
    else $error("Quarter-rate enables not aligned");
  a_div3_gap: assert property ( // RULE11
    core_div3_en |-> gap3_ff == RATIO_W'(`RATIO_CORE3_FIX))
    else $error("Core divide-by-three spacing wrong");

  // Steady PLL mode repeats each period without a realign
  a_half_period: assert property ( // RULE6
    sys_clock_coproc_half && ratio_ok_ff && (mode_ff == MODE_PLL) && !realign ##1 !realign
      |=> sys_clock_coproc_half)
    else $error("Half-rate enable lost its period");
  a_third_period: assert property ( // RULE4
    sys_clock_third && ratio_ok_ff && (mode_ff == MODE_PLL) && !realign
      ##1 !realign ##1 !realign |=> sys_clock_third)
    else $error("Third-rate enable lost its period");

  // No divider ever counts past its held field
  for (genvar j = 0; j < N; j++) begin : g_gap_chk
    a_gap_in_field: assert property ( // RULE13
      gap_ff[j] <= ratio_ff[j])
      else $error("Divider gap ran past its field");
  end

  // Main scenarios
  c_enter_pll:   cover property ($rose(pll_active));
  c_sixth_pulse: cover property (sys_clock_sixth && ratio_ok_ff);
  c_realign:     cover property (realign ##[1:20] sys_clock_third);
  c_bypass_tick: cover property ((mode_ff == MODE_BYPASS) && core_full_rate_en);
  c_leave_pll:   cover property ($fell(pll_active));

endmodule : core_clock_ratio_divider

// ===== verif/ratio_config_model.sv
`timescale 1ns/100ps
`include "core_clock_map.svh"
module ratio_config_model #(
  parameter int RATIO_W = 4
) (
  // Override control from the bench
  input  wire logic                   alt_en,
  input  wire logic [6*RATIO_W-1:0]   alt_fields,
  // Divider fields toward the block
  output logic      [RATIO_W-1:0]     ratio_third,
  output logic      [RATIO_W-1:0]     ratio_trace,
  output logic      [RATIO_W-1:0]     ratio_sixth,
  output logic      [RATIO_W-1:0]     ratio_memif,
  output logic      [RATIO_W-1:0]     ratio_coproc_q,
  output logic      [RATIO_W-1:0]     ratio_coproc_h
);
  // Fixed ratios as divide value minus one; the bench may override them
  always_comb begin
    ratio_third    = RATIO_W'(`RATIO_THIRD_RST);
    ratio_trace    = RATIO_W'(`RATIO_TRACE_RST);
    ratio_sixth    = RATIO_W'(`RATIO_SIXTH_RST);
    ratio_memif    = RATIO_W'(`RATIO_MEMIF_RST);
    ratio_coproc_q = RATIO_W'(`RATIO_COPROCQ_RST);
    ratio_coproc_h = RATIO_W'(`RATIO_COPROCH_RST);
    if (alt_en) begin
      ratio_third    = alt_fields[`IDX_THIRD*RATIO_W +: RATIO_W];
      ratio_trace    = alt_fields[`IDX_TRACE*RATIO_W +: RATIO_W];
      ratio_sixth    = alt_fields[`IDX_SIXTH*RATIO_W +: RATIO_W];
      ratio_memif    = alt_fields[`IDX_MEMIF*RATIO_W +: RATIO_W];
      ratio_coproc_q = alt_fields[`IDX_COPROCQ*RATIO_W +: RATIO_W];
      ratio_coproc_h = alt_fields[`IDX_COPROCH*RATIO_W +: RATIO_W];
    end
  end
endmodule : ratio_config_model

// ===== verif/core_clock_ratio_divider_tb.sv
`timescale 1ns/100ps
module core_clock_ratio_divider_tb;
  import core_clock_pkg::*;
  localparam int RW = 4;
  localparam logic [RW-1:0] REQ [6] = '{4'h2, 4'h3, 4'h5, 4'h3, 4'h3, 4'h1};
  logic            clk        = 1'b0;
  logic            rst_n      = 1'b0;
  logic            pll_mode_req = 1'b0;
  logic            ref_tick   = 1'b0;
  logic            alt_en     = 1'b0;
  logic [6*RW-1:0] alt_fields = '0;
  logic [RW-1:0]   r_third, r_trace, r_sixth, r_memif, r_cq, r_ch;
  logic            core_en, div3_en, s_third, s_trace, s_sixth, s_memif, s_cq, s_ch;
  logic            pll_act, r_ok;
  int              err_count = 0;
  int              comparisons = 0;
  int              seed = 43896;
  int              cycles = 0;
  // Reference state: held fields, mode, ticks since realign, expected outputs
  logic [RW-1:0]   hf [6];
  logic [RW-1:0]   cur [6];
  logic            mode;
  int              n;
  logic [9:0]      e;

  always #20 clk = ~clk;

  core_clock_ratio_divider #(.RATIO_W(RW)) uut (
    .clk(clk), .rst_n(rst_n), .pll_mode_req(pll_mode_req), .ref_tick(ref_tick),
    .ratio_third(r_third), .ratio_trace(r_trace), .ratio_sixth(r_sixth),
    .ratio_memif(r_memif), .ratio_coproc_q(r_cq), .ratio_coproc_h(r_ch),
    .core_full_rate_en(core_en), .core_div3_en(div3_en), .sys_clock_third(s_third),
    .sys_clock_trace_quarter(s_trace), .sys_clock_sixth(s_sixth),
    .sys_clock_memif_quarter(s_memif), .sys_clock_coproc_quarter(s_cq),
    .sys_clock_coproc_half(s_ch), .pll_active(pll_act), .ratio_ok(r_ok));

  ratio_config_model #(.RATIO_W(RW)) cfg (
    .alt_en(alt_en), .alt_fields(alt_fields), .ratio_third(r_third),
    .ratio_trace(r_trace), .ratio_sixth(r_sixth), .ratio_memif(r_memif),
    .ratio_coproc_q(r_cq), .ratio_coproc_h(r_ch));

  task automatic check(input logic act, input logic exp);
    comparisons++;
    if (act !== exp) begin
      err_count++;
      $display("[ERR] t=%0t act=%h exp=%h", $time, act, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  // Random reference ticks for a number of cycles
  task automatic run(input int c);
    repeat (c) begin
      @(posedge clk);
      #2 ref_tick = 1'($random(seed));
    end
  endtask : run

  // A field of N passes every (N+1)th core tick
  function automatic logic exp_pulse(input int ticks, input logic [RW-1:0] field);
    return (ticks % (int'(field) + 1)) == 0;
  endfunction : exp_pulse

  // Expected outputs: any change realigns, else each tick advances all dividers
  always @(posedge clk or negedge rst_n) begin
    logic chg;
    logic ok;
    if (!rst_n) begin
      for (int i = 0; i < 6; i++) hf[i] = REQ[i];
      mode = 1'b0;
      n = 0;
      e = 10'h001;
    end else begin
      cur = '{r_third, r_trace, r_sixth, r_memif, r_cq, r_ch};
      chg = (pll_mode_req !== mode);
      ok = 1'b1;
      for (int i = 0; i < 6; i++) begin
        ok &= (hf[i] == REQ[i]);
        chg |= (cur[i] != hf[i]);
        hf[i] = cur[i];
      end
      mode = pll_mode_req;
      e = {8'h00, mode, ok};
      if (chg) begin
        n = 0;
      end else if (mode || ref_tick) begin
        n++;
        e[9] = 1'b1;
        e[8] = exp_pulse(n, 4'h2);  // Fixed divide-by-three field
        for (int i = 0; i < 6; i++) e[7-i] = exp_pulse(n, hf[i]);
      end
    end
  end

  // Compare every output mid-cycle
  always @(negedge clk) begin
    if (rst_n) begin
      check(core_en, e[9]);
      check(div3_en, e[8]);
      check(s_third, e[7]);
      check(s_trace, e[6]);
      check(s_sixth, e[5]);
      check(s_memif, e[4]);
      check(s_cq, e[3]);
      check(s_ch, e[2]);
      check(pll_act, e[1]);
      check(r_ok, e[0]);
    end
  end

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles >= 3000) begin
      err_count++;
      complete_run();
    end
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    #2 rst_n = 1'b1;
    check(pll_act, 1'b0);
    run(60);
    pll_mode_req = 1'b1;
    run(60);
    alt_en = 1'b1;
    // Random fields, all-zero and all-max corners, back-to-back changes
    for (int k = 0; k < 24; k++) begin
      alt_fields = (k == 0) ? '0 : (k == 1) ? '1 : (6*RW)'($random(seed));
      pll_mode_req = (k < 12) | 1'($random(seed));
      run(1 + ($unsigned($random(seed)) % 24));
    end
    alt_en = 1'b0;
    pll_mode_req = 1'b1;
    run(40);
    // Reset in mid-run returns to bypass
    rst_n = 1'b0;
    run(3);
    rst_n = 1'b1;
    check(pll_act, 1'b0);
    run(30);
    pll_mode_req = 1'b0;
    run(30);
    complete_run();
  end
endmodule : core_clock_ratio_divider_tb
